// ===== core/emt_pkg.sv
// Purpose: Shared constants and types for the external memory mode and
//          strobe timing block.
// Assumes: One system clock, asynchronous active-low reset.
// Notes:   Register offsets are the register port addresses.
//
// How it works
// - Mode 00 serves every external move from on-chip RAM only.
// - Mode 00 wraps addresses modulo the 8 kB on-chip size.
// - Eight-bit moves use page register high byte, R0 or low byte.
// - Sixteen-bit moves take the whole address from the data pointer.
// - Mode 01 sends addresses below the boundary on-chip, above off-chip.
// - Mode 01 eight-bit off-chip moves leave upper pins undriven.
// - Split modes: sixteen-bit moves decide by pointer, drive all sixteen bits.
// - Mode 10 eight-bit off-chip moves drive page high and R0/low.
// - Mode 11 sends every move off-chip; on-chip RAM is invisible.
// - Mode 11 eight-bit moves ignore the page and leave upper pins undriven.
// - Setup field bits 7:6 inserts 0 to 3 setup cycles.
// - Width field bits 5:2 gives strobe width of code plus one cycles.
// - Hold field bits 1:0 keeps address 0 to 3 cycles after strobe.
// - Off-chip move lasts setup, strobe, hold plus 4 cycles overhead.
// - Multiplexed access adds at least 2 cycles of latch pulse phases.
// - Timing register resets to all ones.
// - Non-multiplexed use drives address and data on separate pins.
// - Codes 101, 110, 111 are non-multiplexed with modes 01, 10, 11.
// - Mux select 0 means multiplexed, 1 means separate pins.
// - Latch pulse field sets high and low times 1 to 4 cycles.
// - Low address byte sits on shared pins while latch strobe is high.

package emt_pkg;

    localparam logic [7:0] EMT_PAGE_OFS = 8'ha8;
    localparam logic [7:0] EMT_CFG_OFS = 8'ha9;
    localparam logic [7:0] EMT_TIMING_OFS = 8'haa;
    localparam logic [7:0] EMT_STATUS_OFS = 8'hab;

    localparam logic [7:0] EMT_TIMING_RST = 8'hff;
    localparam logic [4:0] EMT_CFG_RST = 5'h03;
    localparam logic [7:0] EMT_PAGE_RST = 8'h00;

    localparam int EMT_SETUP_HI = 7;
    localparam int EMT_SETUP_LO = 6;
    localparam int EMT_WIDTH_HI = 5;
    localparam int EMT_WIDTH_LO = 2;
    localparam int EMT_HOLD_HI = 1;
    localparam int EMT_HOLD_LO = 0;
    localparam int EMT_MUX_BIT = 4;
    localparam int EMT_MODE_HI = 3;
    localparam int EMT_MODE_LO = 2;
    localparam int EMT_ALE_HI = 1;
    localparam int EMT_ALE_LO = 0;

    localparam logic [1:0] EMT_MODE_INT = 2'h0;
    localparam logic [1:0] EMT_MODE_SPLIT = 2'h1;
    localparam logic [1:0] EMT_MODE_BANK = 2'h2;
    localparam logic [1:0] EMT_MODE_EXT = 2'h3;

    // Prepare cycle plus tail cycles give the fixed overhead.
    localparam int EMT_OVERHEAD_CYC = 4;
    localparam logic [4:0] EMT_TAIL_CYC = 5'(EMT_OVERHEAD_CYC - 1);
    localparam int EMT_ONCHIP_BYTES = 8192;

    typedef enum logic [3:0] {
        EMT_IDLE, EMT_PREP, EMT_ALE_HIGH, EMT_ALE_LOW, EMT_SETUP,
        EMT_STROBE, EMT_HOLD, EMT_TAIL, EMT_INT
    } emt_state_t;

    typedef struct packed {
        logic req;          // One-cycle move request.
        logic write;        // 1 for a write move.
        logic wide;         // 1 for a sixteen-bit move.
        logic use_one;      // 1 selects indirect_reg_one.
        logic [7:0] indirect_reg_zero;
        logic [7:0] indirect_reg_one;
        logic [15:0] data_pointer;
        logic [7:0] wdata;
    } emt_move_req_t;

    typedef struct packed {
        logic [15:0] addr;
        logic addr_hi_oe_n;
        logic addr_lo_oe_n;
        logic [7:0] data_out;
        logic data_oe_n;
        logic ale;
        logic rd_n;
        logic wr_n;
    } emt_pins_t;

endpackage

// ===== core/emt_ext_mem.sv
// Purpose: External move routing, on-chip RAM and off-chip strobe timing.
// Assumes: Move requests and pin inputs are synchronous to sys_clk.
// Notes:   Requests that arrive while busy are ignored.

`timescale 1ns/100ps

module emt_ext_mem #(
    parameter int ONCHIP_BYTES = emt_pkg::EMT_ONCHIP_BYTES
) (
    input wire logic sys_clk,                   // System clock, 20 MHz.
    input wire logic rst_n,                     // Asynchronous reset.
    input wire logic [7:0] reg_addr,            // Register address.
    input wire logic [7:0] reg_wdata,           // Register write data.
    input wire logic reg_wr,                    // Register write strobe.
    input wire logic reg_rd,                    // Register read strobe.
    output logic [7:0] reg_rdata,               // Read data, next cycle.
    input wire emt_pkg::emt_move_req_t move,    // Move request bundle.
    output logic move_busy,                     // Move in progress.
    output logic move_done,                     // One-cycle completion.
    output logic [7:0] move_rdata,              // Read result.
    output emt_pkg::emt_pins_t pins,            // External pin drive.
    input wire logic [7:0] data_in              // External data pins.
);
    import emt_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        emt_state_t st;
        logic [4:0] cnt;
        logic [15:0] addr;
        logic hi_en;
        logic wr;
        logic [7:0] wdat;
        logic [7:0] rdat;
        logic [7:0] tc;
        logic [4:0] cfg;
        logic [7:0] page;
        logic [7:0] rd_bus;
        logic last_off;
    } emt_core_t;

    localparam int AW = $clog2(ONCHIP_BYTES);

    emt_core_t s_reg;
    emt_core_t s_next;
    logic [7:0] onchip_ext_ram [ONCHIP_BYTES];
    logic [15:0] eff;
    logic onchip;
    logic mux_mode;
    logic [1:0] mode;
    logic [AW-1:0] int_addr;
    logic int_wr;

    assign mux_mode = ~s_reg.cfg[EMT_MUX_BIT];
    assign mode = s_reg.cfg[EMT_MODE_HI:EMT_MODE_LO];

    // ------------------------------------------------------------
    // Phase lengths
    // ------------------------------------------------------------
    // A zero length means the phase is skipped altogether.
    function automatic logic [4:0] phase_len(emt_state_t p,
            logic [7:0] tc, logic mux, logic [1:0] ale);
        logic [4:0] n;
        n = 5'h00;
        case (p)
            EMT_ALE_HIGH,
            EMT_ALE_LOW: n = mux ? 5'({3'h0, ale} + 5'h01) : 5'h00;
            EMT_SETUP: n = 5'(tc[EMT_SETUP_HI:EMT_SETUP_LO]);
            EMT_STROBE: n = 5'({1'b0, tc[EMT_WIDTH_HI:EMT_WIDTH_LO]})
                + 5'h01;
            EMT_HOLD: n = 5'(tc[EMT_HOLD_HI:EMT_HOLD_LO]);
            EMT_TAIL: n = EMT_TAIL_CYC;
            default: n = 5'h00;
        endcase
        return n;
    endfunction

    // Next non-empty phase after cur; the tail is never empty.
    function automatic emt_state_t next_phase(emt_state_t cur,
            logic [7:0] tc, logic mux, logic [1:0] ale);
        emt_state_t r;
        logic found;
        r = EMT_TAIL;
        found = 1'b0;
        for (int k = 2; k <= 7; k++) begin
            if (!found && k > int'(cur) &&
                    phase_len(emt_state_t'(k), tc, mux, ale) != 5'h00) begin
                r = emt_state_t'(k);
                found = 1'b1;
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Address routing
    // ------------------------------------------------------------
    always_comb begin
        eff = move.wide ? move.data_pointer
            : {s_reg.page, move.use_one ? move.indirect_reg_one
                                        : move.indirect_reg_zero};
        case (mode)
            EMT_MODE_INT: onchip = 1'b1;
            EMT_MODE_EXT: onchip = 1'b0;
            default: onchip = 32'(eff) < ONCHIP_BYTES;
        endcase
        int_addr = eff[AW-1:0];
        int_wr = move.req && !move_busy && onchip && move.write;
    end

    // On-chip RAM kept outside the state record; it is storage only.
    always_ff @(posedge sys_clk) begin
        if (int_wr) begin
            onchip_ext_ram[int_addr] <= move.wdata;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        emt_state_t nx;
        logic [1:0] ale;
        nx = EMT_IDLE;
        ale = s_reg.cfg[EMT_ALE_HI:EMT_ALE_LO];
        s_next = s_reg;
        s_next.rd_bus = 8'h00;

        // Register port; timing is read live, so change it only when idle.
        if (reg_wr) begin
            if (reg_addr == EMT_PAGE_OFS) begin
                s_next.page = reg_wdata;
            end else if (reg_addr == EMT_CFG_OFS) begin
                s_next.cfg = reg_wdata[4:0];
            end else if (reg_addr == EMT_TIMING_OFS) begin
                s_next.tc = reg_wdata;
            end
        end
        if (reg_rd) begin
            if (reg_addr == EMT_PAGE_OFS) begin
                s_next.rd_bus = s_reg.page;
            end else if (reg_addr == EMT_CFG_OFS) begin
                s_next.rd_bus = {3'h0, s_reg.cfg};
            end else if (reg_addr == EMT_TIMING_OFS) begin
                s_next.rd_bus = s_reg.tc;
            end else if (reg_addr == EMT_STATUS_OFS) begin
                s_next.rd_bus = {6'h00, s_reg.last_off, move_busy};
            end
        end

        case (s_reg.st)
            EMT_IDLE: begin
                if (move.req) begin
                    s_next.wr = move.write;
                    s_next.wdat = move.wdata;
                    s_next.last_off = ~onchip;
                    if (onchip) begin
                        s_next.st = EMT_INT;
                        if (!move.write) begin
                            s_next.rdat = onchip_ext_ram[int_addr];
                        end
                    end else begin
                        s_next.st = EMT_PREP;
                        s_next.addr = eff;
                        // Bank select or wide moves own the upper pins.
                        s_next.hi_en = move.wide ||
                            (mode == EMT_MODE_BANK);
                    end
                end
            end
            EMT_INT: begin
                s_next.st = EMT_IDLE;
            end
            EMT_PREP: begin
                nx = next_phase(EMT_PREP, s_reg.tc, mux_mode, ale);
                s_next.st = nx;
                s_next.cnt = phase_len(nx, s_reg.tc, mux_mode, ale) - 5'h01;
            end
            EMT_ALE_HIGH, EMT_ALE_LOW, EMT_SETUP,
            EMT_STROBE, EMT_HOLD, EMT_TAIL: begin
                if (s_reg.cnt != 5'h00) begin
                    s_next.cnt = s_reg.cnt - 5'h01;
                end else if (s_reg.st == EMT_TAIL) begin
                    s_next.st = EMT_IDLE;
                end else begin
                    nx = next_phase(s_reg.st, s_reg.tc, mux_mode, ale);
                    s_next.st = nx;
                    s_next.cnt = phase_len(nx, s_reg.tc, mux_mode, ale)
                        - 5'h01;
                end
                // Sample read data on the last strobe cycle.
                if (s_reg.st == EMT_STROBE && s_reg.cnt == 5'h00 &&
                        !s_reg.wr) begin
                    s_next.rdat = data_in;
                end
            end
            default: begin
                s_next.st = EMT_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg.st <= EMT_IDLE;
            s_reg.cnt <= 5'h00;
            s_reg.addr <= 16'h0000;
            s_reg.hi_en <= 1'b0;
            s_reg.wr <= 1'b0;
            s_reg.wdat <= 8'h00;
            s_reg.rdat <= 8'h00;
            s_reg.tc <= EMT_TIMING_RST;
            s_reg.cfg <= EMT_CFG_RST;
            s_reg.page <= EMT_PAGE_RST;
            s_reg.rd_bus <= 8'h00;
            s_reg.last_off <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic active;
    logic ale_ph;

    assign active = s_reg.st inside {EMT_ALE_HIGH, EMT_ALE_LOW, EMT_SETUP,
                                     EMT_STROBE, EMT_HOLD};
    assign ale_ph = s_reg.st inside {EMT_ALE_HIGH, EMT_ALE_LOW};

    always_comb begin
        reg_rdata = s_reg.rd_bus;
        move_busy = s_reg.st != EMT_IDLE;
        move_done = (s_reg.st == EMT_INT) ||
            (s_reg.st == EMT_TAIL && s_reg.cnt == 5'h00);
        move_rdata = s_reg.rdat;

        pins.addr = s_reg.addr;
        pins.addr_hi_oe_n = ~(active && s_reg.hi_en);
        // Separate low address pins are used only without multiplexing.
        pins.addr_lo_oe_n = ~(active && !mux_mode);
        pins.ale = s_reg.st == EMT_ALE_HIGH;
        if (mux_mode && ale_ph) begin
            // Low byte stays on the shared pins through the latch low
            // phase so the external latch sees it well past the fall.
            pins.data_out = s_reg.addr[7:0];
            pins.data_oe_n = 1'b0;
        end else begin
            pins.data_out = s_reg.wdat;
            pins.data_oe_n = ~(s_reg.wr &&
                (s_reg.st inside {EMT_SETUP, EMT_STROBE, EMT_HOLD}));
        end
        pins.rd_n = ~(s_reg.st == EMT_STROBE && !s_reg.wr);
        pins.wr_n = ~(s_reg.st == EMT_STROBE && s_reg.wr);
    end

endmodule // emt_ext_mem

// ===== verif/emt_ext_mem_checker.sv
// Purpose: Port assertions for the external memory block.
// Assumes: Timing and config are only written while no move runs.
// Notes:   Timing and config are mirrored from the register writes.
`timescale 1ns/100ps
module emt_ext_mem_checker
    import emt_pkg::*;
(
    input wire logic sys_clk, // System clock.
    input wire logic rst_n, // Asynchronous reset.
    input wire logic [7:0] reg_addr, // Register address.
    input wire logic [7:0] reg_wdata, // Register write data.
    input wire logic reg_wr, // Register write strobe.
    input wire logic reg_rd, // Register read strobe.
    input wire logic [7:0] reg_rdata, // Register read data.
    input wire emt_pkg::emt_move_req_t move, // Move request.
    input wire logic move_busy, // Move in progress.
    input wire logic move_done, // Move completion.
    input wire emt_pkg::emt_pins_t pins // Pin drive.
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] tim_q;
    logic [4:0] cfg_q;
    logic [4:0] str_cnt;
    logic [2:0] ale_cnt;
    logic take;
    assign take = move.req && !move_busy;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tim_q <= EMT_TIMING_RST;
            cfg_q <= EMT_CFG_RST;
            str_cnt <= 5'h00;
            ale_cnt <= 3'h0;
        end else begin
            if (reg_wr && reg_addr == EMT_TIMING_OFS) tim_q <= reg_wdata;
            if (reg_wr && reg_addr == EMT_CFG_OFS) cfg_q <= reg_wdata[4:0];
            str_cnt <= (!pins.rd_n || !pins.wr_n) ? str_cnt + 5'h01 : 5'h00;
            ale_cnt <= pins.ale ? ale_cnt + 3'h1 : 3'h0;
        end
    end
    AST_STROBE_EXCL: assert property (pins.rd_n || pins.wr_n)
        else $error("both strobes low");
    AST_STROBE_WIDTH: assert property ($rose(pins.rd_n && pins.wr_n) |->
        str_cnt == {1'b0, tim_q[5:2]} + 5'h01) else $error("strobe width");
    AST_ALE_WIDTH: assert property ($fell(pins.ale) |->
        ale_cnt == {1'b0, cfg_q[1:0]} + 3'h1) else $error("latch pulse");
    AST_INT_ONCHIP: assert property (take && cfg_q[3:2] == EMT_MODE_INT
        |=> move_done && pins.rd_n && pins.wr_n) else $error("on-chip move");
    AST_EXT_OFFCHIP: assert property (take && cfg_q[3:2] == EMT_MODE_EXT
        |=> (!move_done)[*4]) else $error("external move too short");
    AST_NONMUX_NO_ALE: assert property (cfg_q[EMT_MUX_BIT]
        |-> !pins.ale) else $error("latch pulse in separate-pin use");
    AST_ALE_ADDR: assert property (pins.ale |-> !pins.data_oe_n &&
        pins.data_out == pins.addr[7:0]) else $error("latch address");
    AST_WRITE_DRIVE: assert property (!pins.wr_n |-> !pins.data_oe_n)
        else $error("write data not driven");
    AST_READ_RELEASE: assert property (!pins.rd_n |-> pins.data_oe_n)
        else $error("data pins driven during read");
    AST_REG_TIMING: assert property (reg_rd &&
        reg_addr == EMT_TIMING_OFS |=> reg_rdata == tim_q)
        else $error("timing readback");
endmodule // emt_ext_mem_checker

bind emt_ext_mem emt_ext_mem_checker emt_ext_mem_checker_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .move(move), .move_busy(move_busy),
    .move_done(move_done), .pins(pins));

// ===== verif/emt_sram_model.sv
// Purpose: Behavioural byte-wide external memory on the block's pins.
// Assumes: Undriven upper address pins read as zero from the port latch.
// Notes:   Released data pins toggle so stale values never look valid.
`timescale 1ns/100ps
module emt_sram_model
    import emt_pkg::*;
(
    input wire logic sys_clk, // System clock.
    input wire emt_pkg::emt_pins_t pins, // Block pin drive.
    output logic [7:0] data_in // Data pins back to the block.
);
    logic [7:0] mem [0:65535];
    logic [7:0] lat_lo;
    logic [7:0] prev = 8'h5a;
    logic [15:0] key;
    always @(posedge sys_clk) begin
        if (pins.ale) lat_lo <= pins.data_out;
        if (!pins.wr_n) mem[key] <= pins.data_out;
        prev <= data_in;
    end
    always @* begin
        key = {pins.addr_hi_oe_n ? 8'h00 : pins.addr[15:8],
               pins.addr_lo_oe_n ? lat_lo : pins.addr[7:0]};
        data_in = !pins.rd_n ? mem[key] : ~prev;
    end
endmodule // emt_sram_model

// ===== verif/tb_top.sv
// Purpose: Self-checking bench for the external memory block.
// Assumes: Registers are rewritten only between moves.
// Notes:   A reference model predicts address, length and data of moves.
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("Error %0t: got %h want %h", $time, g, e); end end
module tb_top;
    import emt_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata, move_rdata, data_in, tim, cfg, page, wv;
    logic move_busy, move_done;
    logic [15:0] dp;
    emt_move_req_t mv = '0;
    emt_pins_t pins;
    int n_fail = 0, compares = 0, cyc = 0, seed = 32'hac64;
    logic [7:0] on_mem [int];
    logic [7:0] ext_mem [int];
    always #25 sys_clk = ~sys_clk;
    emt_ext_mem emt_ext_mem_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .move(mv),
        .move_busy(move_busy), .move_done(move_done),
        .move_rdata(move_rdata), .pins(pins), .data_in(data_in));
    emt_sram_model emt_sram_model_inst (.sys_clk(sys_clk), .pins(pins),
        .data_in(data_in));
    task automatic conclude();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic reg_wr8(input logic [7:0] a, d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_rd8(input logic [7:0] a, e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        `CHK(reg_rdata, e)
    endtask
    // Length and placement are predicted before the request goes out.
    task automatic move_op(input logic wr, wd, input logic [15:0] d,
                           input logic [7:0] v);
        int n, en;
        logic [15:0] eff, key;
        logic off, hi, seen;
        eff = wd ? d : {page, d[7:0]};
        off = cfg[3:2] == 2'h3 || (cfg[3:2] != 2'h0 && eff >= 16'h2000);
        hi = wd || cfg[3:2] == 2'h2;
        key = off ? {hi ? eff[15:8] : 8'h00, eff[7:0]} : eff % 16'h2000;
        en = 5 + tim[7:6] + tim[5:2] + tim[1:0];
        en = off ? en + (cfg[4] ? 0 : 2 * (cfg[1:0] + 1)) : 1;
        seen = 1'b0;
        n = 0;
        @(posedge sys_clk);
        mv <= '{1'b1, wr, wd, v[7], v[7] ? ~eff[7:0] : eff[7:0],
                v[7] ? eff[7:0] : ~eff[7:0], d, v};
        @(posedge sys_clk);
        mv.req <= 1'b0;
        do begin
            @(negedge sys_clk);
            n++;
            `CHK(move_busy, 1'b1)
            if (!seen && !(pins.rd_n && pins.wr_n)) begin
                seen = 1'b1;
                `CHK(pins.addr_hi_oe_n, !hi)
                if (hi) `CHK(pins.addr[15:8], eff[15:8])
                `CHK(pins.addr_lo_oe_n, !cfg[4])
                `CHK(pins.addr[7:0], eff[7:0])
                if (!cfg[4]) `CHK(emt_sram_model_inst.lat_lo, eff[7:0])
                `CHK({pins.rd_n, pins.wr_n}, {wr, !wr})
            end
        end while (move_done !== 1'b1 && n < 200);
        `CHK(seen, off)
        `CHK(n, en)
        if (wr) begin
            if (off) ext_mem[key] = v;
            else on_mem[key] = v;
        end else if (off) `CHK(move_rdata, ext_mem[key])
        else `CHK(move_rdata, on_mem[key])
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        reg_rd8(EMT_TIMING_OFS, 8'hff);
        reg_rd8(EMT_CFG_OFS, {3'h0, EMT_CFG_RST});
        reg_rd8(EMT_PAGE_OFS, EMT_PAGE_RST);
        reg_rd8(8'h00, 8'h00);
        reg_wr8(EMT_CFG_OFS, 8'hff);
        reg_rd8(EMT_CFG_OFS, 8'h1f);
        // Every pin-use and mode code, mixing on-chip and off-chip moves.
        for (int m = 0; m < 8; m++) begin
            for (int i = 0; i < 6; i++) begin
                tim = 8'($random(seed));
                cfg = {3'h0, m[2], m[1:0], i[1:0]};
                page = 8'($random(seed));
                dp = 16'($random(seed));
                if (i[0]) page[7:5] = 3'h0;
                if (i[0]) dp[15:13] = 3'h0;
                reg_wr8(EMT_TIMING_OFS, tim);
                reg_wr8(EMT_CFG_OFS, cfg);
                reg_wr8(EMT_PAGE_OFS, page);
                reg_rd8(EMT_TIMING_OFS, tim);
                wv = 8'($random(seed));
                move_op(1'b1, i > 2, dp, wv);
                if (m[1:0] == 2'h0) dp[13] = ~dp[13];
                move_op(1'b0, i > 2, dp, 8'($random(seed)));
            end
        end
        // The last move ran in external-only mode, so it went off-chip.
        reg_rd8(EMT_STATUS_OFS, 8'h02);
        conclude();
    end
endmodule // tb_top
